//--- inc/pfm_pkg.sv
package pfm_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [5:0] OFS_SEL0 = 6'h00;
  localparam logic [5:0] OFS_SEL1 = 6'h04;
  localparam logic [5:0] OFS_SEL2 = 6'h08;
  localparam logic [5:0] OFS_SEL3 = 6'h0c;
  localparam logic [5:0] OFS_SEL4 = 6'h10;
  localparam logic [5:0] OFS_SEL5 = 6'h14;
  localparam logic [5:0] OFS_SEL6 = 6'h18;
  localparam logic [5:0] OFS_ENC_FILT = 6'h20;
  localparam logic [5:0] OFS_TMR_DIS = 6'h24;
  localparam logic [5:0] OFS_INT_STATUS = 6'h28;
  localparam logic [5:0] OFS_INT_MASK = 6'h2c;
  // Reset values: default option bit of each used byte set
  localparam logic [31:0] RST_SEL0 = 32'h0000_0100;
  localparam logic [31:0] RST_SEL1 = 32'h0101_0101;
  localparam logic [31:0] RST_SEL2 = 32'h0001_0101;
  localparam logic [31:0] RST_SEL3 = 32'h0101_0001;
  localparam logic [31:0] RST_SEL4 = 32'h0001_0101;
  localparam logic [31:0] RST_SEL5 = 32'h0000_0100;
  localparam logic [31:0] RST_SEL6 = 32'h0000_0100;
  localparam logic [31:0] RST_ENC_FILT = 32'h0101_0101;
  localparam logic [31:0] RST_TMR_DIS = 32'h0000_0001;
  // Field positions
  localparam int ENC_A_POS = 0;
  localparam int ENC_B_POS = 8;
  localparam int ENC_I_POS = 16;
  localparam int ENC_S_POS = 24;
  localparam int TDIS_GPIO_BIT = 0;
  localparam int TDIS_ERR_BIT = 1;
  // Interrupt status bits
  localparam int IRQ_PRIV_ERR = 0;
  localparam int IRQ_ENC_CHG = 1;
  localparam int IRQ_W = 2;
  // Qualifier span: fixed 6-bit counter
  localparam int QUAL_W = 6;
  localparam logic [5:0] QUAL_MAX = 6'h3f;

  typedef struct packed {
    logic wr;
    logic rd;
    logic priv;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pfm_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic err;
  } pfm_rsp_s;

  // Peripheral outputs to multiplex
  typedef struct packed {
    logic [7:0] gpio_a;
    logic [3:1] serial3_cs_n;
    logic [3:1] serial2_cs_n;
    logic [3:1] buf_cs_n;
    logic buf_ena_n;
    logic serial3_clk;
    logic serial3_cs0_n;
    logic serial3_ena_n;
    logic converter_event;
    logic ext_clk;
    logic [31:17] timer;
    logic enc_a;
    logic enc_b;
    logic enc_i;
    logic enc_s;
  } pfm_func_s;

  typedef enum logic [1:0] {
    PFM_OPT_DEF = 2'b00,
    PFM_OPT_2 = 2'b01,
    PFM_OPT_3 = 2'b10
  } pfm_opt_e;
endpackage

//--- logic/pfm_pin_function_mux.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Only output drivers are switched; pin inputs fan out to all sharers.
// - After reset each pin drives its default function.
// - Options picked by per-pin register and bit mapping.
// - One byte per pin: bit0 default, bit1 second, bit2 third.
// - Bit 16 of select register 2 set at reset; port A7 on pin 18.
// - Shared pin input goes to port and timer together, unselected.
// - Select writes only when privileged; others get an error response.
// - All-zero select register gives defaults on its pins.
// - More than one bit set in a byte gives the default.
// - Direct-sync bit set: encoder A two-flop synchronised only.
// - Qualify mode: synchronised then qualified by 6-bit counter.
// - Both filter bits zero behaves as direct-sync.
// - Encoder B, index, strobe use bits 8/9, 16/17, 24/25.
// - Disable source bit 0 set: port A5 drives timer disable directly.
// - Source bit1 only: encoder error synchronised, inverted, drives disable.
// - Both source bits zero behaves as port A5.
module pfm_pin_function_mux
  import pfm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire pfm_pkg::pfm_req_s bus_req,
  output pfm_pkg::pfm_rsp_s bus_rsp,
  output logic irq,
  // Peripheral outputs
  input wire pfm_pkg::pfm_func_s func,
  // Pin outputs: pins 1,2,5,8,9,10,12,18,93,27,39,68,36,38,37,58
  output logic [15:0] pin_out,
  // Pin inputs, raw from pads
  input wire logic [15:0] pin_in,
  input wire logic encoder_in_a,
  input wire logic encoder_in_b,
  input wire logic encoder_index,
  input wire logic encoder_strobe,
  input wire logic encoder_error,
  // Input fan-out to peripherals
  output logic [15:0] pin_to_gpio,
  output logic [15:0] pin_to_timer,
  output logic [15:0] pin_to_serial,
  output logic [3:0] encoder_filtered,
  output logic timer_pin_disable_n
);
  import pfm_pkg::*;

  logic [31:0] sel [0:6];
  logic [31:0] enc_filt;
  logic [31:0] tmr_dis;
  logic [IRQ_W-1:0] int_status;
  logic [IRQ_W-1:0] int_mask;
  logic priv_err_evt;
  logic enc_chg_evt;

  // Returns option for one byte; anything but 8'h02 or 8'h04 gives default
  function automatic pfm_opt_e decode_byte(input logic [7:0] b);
    case (b)
      8'h02: decode_byte = PFM_OPT_2;
      8'h04: decode_byte = PFM_OPT_3;
      default: decode_byte = PFM_OPT_DEF;
    endcase
  endfunction

  function automatic logic pick3(input pfm_opt_e o, input logic d, input logic s2, input logic s3);
    case (o)
      PFM_OPT_2: pick3 = s2;
      PFM_OPT_3: pick3 = s3;
      default: pick3 = d;
    endcase
  endfunction

  // Offset 0x1c is a hole in the select map, so no error there
  wire logic sel_addr = bus_req.addr <= OFS_TMR_DIS && bus_req.addr != 6'h1c;
  wire logic wr_ok = bus_req.wr && bus_req.priv;

  // Privileged-only writes; unprivileged write gets error on the next cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel[0] <= RST_SEL0;
      sel[1] <= RST_SEL1;
      sel[2] <= RST_SEL2;
      sel[3] <= RST_SEL3;
      sel[4] <= RST_SEL4;
      sel[5] <= RST_SEL5;
      sel[6] <= RST_SEL6;
      enc_filt <= RST_ENC_FILT;
      tmr_dis <= RST_TMR_DIS;
    end else if (wr_ok) begin
      case (bus_req.addr)
        OFS_SEL0: sel[0] <= bus_req.wdata;
        OFS_SEL1: sel[1] <= bus_req.wdata;
        OFS_SEL2: sel[2] <= bus_req.wdata;
        OFS_SEL3: sel[3] <= bus_req.wdata;
        OFS_SEL4: sel[4] <= bus_req.wdata;
        OFS_SEL5: sel[5] <= bus_req.wdata;
        OFS_SEL6: sel[6] <= bus_req.wdata;
        OFS_ENC_FILT: enc_filt <= bus_req.wdata;
        OFS_TMR_DIS: tmr_dis <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  assign priv_err_evt = bus_req.wr && !bus_req.priv && sel_addr;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      int_mask <= '0;
    end else if (bus_req.wr && bus_req.addr == OFS_INT_MASK) begin
      int_mask <= bus_req.wdata[IRQ_W-1:0];
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      int_status <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_PRIV_ERR && priv_err_evt) || (i == IRQ_ENC_CHG && enc_chg_evt))
          int_status[i] <= 1'b1;
        else if (bus_req.wr && bus_req.addr == OFS_INT_STATUS && bus_req.wdata[i])
          int_status[i] <= 1'b0;
      end
    end
  end

  assign irq = |(int_status & int_mask);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rsp <= '0;
    end else begin
      bus_rsp.err <= priv_err_evt;
      bus_rsp.rdata <= '0;
      // Reserved select bits read back as stored
      if (bus_req.rd) begin
        case (bus_req.addr)
          OFS_SEL0: bus_rsp.rdata <= sel[0];
          OFS_SEL1: bus_rsp.rdata <= sel[1];
          OFS_SEL2: bus_rsp.rdata <= sel[2];
          OFS_SEL3: bus_rsp.rdata <= sel[3];
          OFS_SEL4: bus_rsp.rdata <= sel[4];
          OFS_SEL5: bus_rsp.rdata <= sel[5];
          OFS_SEL6: bus_rsp.rdata <= sel[6];
          OFS_ENC_FILT: bus_rsp.rdata <= enc_filt;
          OFS_TMR_DIS: bus_rsp.rdata <= tmr_dis;
          OFS_INT_STATUS: bus_rsp.rdata <= {{(32-IRQ_W){1'b0}}, int_status};
          OFS_INT_MASK: bus_rsp.rdata <= {{(32-IRQ_W){1'b0}}, int_mask};
          default: bus_rsp.rdata <= '0;
        endcase
      end
    end
  end

  // Output multiplexing; pins are combinational so selection acts at once
  always_comb begin
    // Pin 1
    pin_out[0] = pick3(
      decode_byte(sel[0][15:8]),
      func.gpio_a[0],
      func.serial3_cs_n[3],
      func.gpio_a[0]
    );

    // Pin 2
    pin_out[1] = pick3(
      decode_byte(sel[1][7:0]),
      func.gpio_a[1],
      func.serial3_cs_n[2],
      func.gpio_a[1]
    );

    // Pin 5
    pin_out[2] = pick3(
      decode_byte(sel[1][15:8]),
      func.gpio_a[2],
      func.serial3_cs_n[1],
      func.gpio_a[2]
    );

    // Pin 8
    pin_out[3] = pick3(
      decode_byte(sel[1][23:16]),
      func.gpio_a[3],
      func.serial2_cs_n[3],
      func.gpio_a[3]
    );

    // Pin 9
    pin_out[4] = pick3(
      decode_byte(sel[1][31:24]),
      func.gpio_a[4],
      func.serial2_cs_n[2],
      func.gpio_a[4]
    );

    // Pin 10
    pin_out[5] = pick3(
      decode_byte(sel[2][7:0]),
      func.gpio_a[5],
      func.ext_clk,
      func.gpio_a[5]
    );

    // Pin 12
    pin_out[6] = pick3(
      decode_byte(sel[2][15:8]),
      func.gpio_a[6],
      func.serial2_cs_n[1],
      func.timer[31]
    );

    // Pin 18: port A7 by default, timer 29 once software swaps the bits
    pin_out[7] = pick3(
      decode_byte(sel[2][23:16]),
      func.gpio_a[7],
      func.timer[29],
      func.gpio_a[7]
    );

    // Pin 93
    pin_out[8] = pick3(
      decode_byte(sel[6][15:8]),
      func.buf_cs_n[1],
      func.enc_s,
      func.timer[17]
    );

    // Pin 27
    pin_out[9] = pick3(
      decode_byte(sel[3][7:0]),
      func.buf_cs_n[2],
      func.timer[20],
      func.timer[19]
    );

    // Pin 39
    pin_out[10] = pick3(
      decode_byte(sel[4][15:8]),
      func.buf_cs_n[3],
      func.timer[26],
      func.buf_cs_n[3]
    );

    // Pin 68
    pin_out[11] = pick3(
      decode_byte(sel[5][15:8]),
      func.buf_ena_n,
      func.timer[23],
      func.timer[30]
    );

    // Pin 36
    pin_out[12] = pick3(
      decode_byte(sel[3][23:16]),
      func.serial3_clk,
      func.enc_a,
      func.serial3_clk
    );

    // Pin 38
    pin_out[13] = pick3(
      decode_byte(sel[4][7:0]),
      func.serial3_cs0_n,
      func.enc_i,
      func.serial3_cs0_n
    );

    // Pin 37
    pin_out[14] = pick3(
      decode_byte(sel[3][31:24]),
      func.serial3_ena_n,
      func.enc_b,
      func.serial3_ena_n
    );

    // Pin 58
    pin_out[15] = pick3(
      decode_byte(sel[4][23:16]),
      func.converter_event,
      func.timer[28],
      func.converter_event
    );
  end

  // Inputs not multiplexed: every sharer sees the pad together
  assign pin_to_gpio = pin_in;
  assign pin_to_timer = pin_in;
  assign pin_to_serial = pin_in;

  // Encoder input filters
  logic [3:0] enc_raw;
  logic [3:0] enc_s1;
  logic [3:0] enc_s2;
  assign enc_raw = {encoder_strobe, encoder_index, encoder_in_b, encoder_in_a};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enc_s1 <= '0;
      enc_s2 <= '0;
    end else begin
      enc_s1 <= enc_raw;
      enc_s2 <= enc_s1;
    end
  end

  wire logic [3:0] enc_pick;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_enc
      localparam int P = (g == 0) ? ENC_A_POS : (g == 1) ? ENC_B_POS : (g == 2) ? ENC_I_POS : ENC_S_POS;
      logic [QUAL_W-1:0] cnt;
      logic qual;
      logic prev;
      logic use_qual;
      // Qualify only when direct bit clear and qualify bit set; 00 acts as direct
      assign use_qual = !enc_filt[P] && enc_filt[P+1];
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          cnt <= '0;
          qual <= 1'b0;
          prev <= 1'b0;
        end else begin
          prev <= enc_s2[g];
          if (enc_s2[g] != prev) begin
            cnt <= '0;
          end else if (cnt == QUAL_MAX) begin
            qual <= enc_s2[g];
          end else begin
            cnt <= cnt + 6'h01;
          end
        end
      end
      assign enc_pick[g] = use_qual ? qual : enc_s2[g];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      encoder_filtered <= '0;
    end else begin
      encoder_filtered <= enc_pick;
    end
  end

  // Raised one cycle ahead of the filtered output changing
  assign enc_chg_evt = |(encoder_filtered ^ enc_pick);

  // Timer disable source
  logic err_s1;
  logic err_s2;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      err_s1 <= 1'b0;
      err_s2 <= 1'b0;
    end else begin
      err_s1 <= encoder_error;
      err_s2 <= err_s1;
    end
  end

  // Port A5 path is a direct wire, so it needs no sync
  // Inverted after the second flop, so no gate sits ahead of the first
  assign timer_pin_disable_n = (!tmr_dis[TDIS_GPIO_BIT] && tmr_dis[TDIS_ERR_BIT])
    ? !err_s2
    : func.gpio_a[5];
endmodule

//--- verification/pfm_pin_function_mux_monitor.sv
`timescale 1ns/1ns
module pfm_pin_function_mux_monitor
  import pfm_pkg::*;
(
  // Clock, reset, register port
  input wire logic sys_clk,
  input wire logic rstn,
  input wire pfm_pkg::pfm_req_s bus_req,
  input wire pfm_pkg::pfm_rsp_s bus_rsp,
  // Pins and peripherals
  input wire pfm_pkg::pfm_func_s func,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_to_gpio,
  input wire logic [15:0] pin_to_timer,
  input wire logic [15:0] pin_to_serial,
  input wire logic encoder_in_a,
  input wire logic [3:0] encoder_filtered,
  input wire logic timer_pin_disable_n
);
  import pfm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Shadow fields, since the registers are not visible here
  logic [7:0] p18;
  logic [1:0] tdis;
  logic [1:0] efa;
  logic [6:0] quiet;
  logic [6:0] stab;
  logic a_q;
  wire pw = bus_req.wr && bus_req.priv;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      p18 <= RST_SEL2[23:16];
      tdis <= RST_TMR_DIS[1:0];
      efa <= RST_ENC_FILT[1:0];
    end else if (pw) begin
      if (bus_req.addr == OFS_SEL2) p18 <= bus_req.wdata[23:16];
      if (bus_req.addr == OFS_TMR_DIS) tdis <= bus_req.wdata[1:0];
      if (bus_req.addr == OFS_ENC_FILT) efa <= bus_req.wdata[1:0];
    end
  end
  // Mode age and input stability, saturating
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      quiet <= 7'h00;
      stab <= 7'h00;
      a_q <= 1'b0;
    end else begin
      quiet <= (pw && bus_req.addr == OFS_ENC_FILT) ? 7'h00 : quiet + {6'h00, quiet != 7'h7f};
      stab <= (encoder_in_a != a_q) ? 7'h00 : stab + {6'h00, stab != 7'h7f};
      a_q <= encoder_in_a;
    end
  end
  a_fanout_gpio: assert property (pin_to_gpio == pin_in)
    else $error("gpio input path differs");
  a_shared_input: assert property (pin_to_timer == pin_in && pin_to_serial == pin_in)
    else $error("shared input path differs");
  a_priv_err: assert property (bus_req.wr && !bus_req.priv && bus_req.addr == OFS_SEL2 |=> bus_rsp.err)
    else $error("no error on unprivileged write");
  a_err_cause: assert property (bus_rsp.err |-> $past(bus_req.wr && !bus_req.priv))
    else $error("error without cause");
  a_pin18_option: assert property (p18 == 8'h02 |-> pin_out[7] == func.timer[29])
    else $error("pin 18 second option wrong");
  a_pin18_default: assert property (p18 != 8'h02 |-> pin_out[7] == func.gpio_a[7])
    else $error("pin 18 default wrong");
  a_disable_src: assert property (tdis != 2'b10 |-> timer_pin_disable_n == func.gpio_a[5])
    else $error("disable source wrong");
  a_enc_direct: assert property (efa != 2'b10 && quiet > 7'h08 |-> encoder_filtered[0] == $past(encoder_in_a, 3))
    else $error("direct sync latency wrong");
  a_qual_span: assert property (efa == 2'b10 && quiet > 7'h02 && $changed(encoder_filtered[0]) |-> stab > 7'h3c)
    else $error("qualified change too early");
  c_err: cover property (bus_rsp.err);
  c_opt2: cover property (p18 == 8'h02);
  c_qual: cover property (efa == 2'b10 && $changed(encoder_filtered[0]));
endmodule

//--- verification/pfm_periph_model.sv
`timescale 1ns/1ns
module pfm_periph_model
  import pfm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Peripheral output levels
  output pfm_pkg::pfm_func_s func
);
  import pfm_pkg::*;
  logic [6:0] cnt;
  // Odd step keeps neighbouring sources apart, so a wrong mux leg shows
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 7'h00;
    end else begin
      cnt <= cnt + 7'h05;
    end
  end
  assign func = {6{cnt}};
endmodule

//--- verification/tb_pin_function_mux.sv
`timescale 1ns/1ns
module tb_pin_function_mux;
  import pfm_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  pfm_req_s req = '0;
  pfm_rsp_s rsp;
  pfm_func_s func;
  logic [15:0] pin_out, to_gpio, to_timer, to_serial;
  logic [15:0] pin_in = 16'h0000;
  logic [3:0] enc = 4'h0;
  logic [3:0] filt;
  logic enc_err = 1'b0;
  logic irq, dis_n;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rq;
  logic [5:0] ra [9] = '{OFS_SEL0, OFS_SEL1, OFS_SEL2, OFS_SEL3, OFS_SEL4, OFS_SEL5, OFS_SEL6, OFS_ENC_FILT, OFS_TMR_DIS};
  logic [31:0] rv [9] = '{RST_SEL0, RST_SEL1, RST_SEL2, RST_SEL3, RST_SEL4, RST_SEL5, RST_SEL6, RST_ENC_FILT, RST_TMR_DIS};
  // Top bit: pin 18 should carry the timer
  logic [32:0] rows [6] = '{33'h0_0001_0101, 33'h1_0002_0101, 33'h0_0003_0101, 33'h0_0000_0000, 33'h0_0004_0101,
    33'h0_0001_0101};
  logic [31:0] emode [3] = '{32'h0101_0101, 32'h0000_0000, 32'h0303_0303};
  always #20 sys_clk = ~sys_clk;
  pfm_periph_model peri (.sys_clk(sys_clk), .rstn(rstn), .func(func));
  pfm_pin_function_mux uut (
    .sys_clk(sys_clk), .rstn(rstn), .bus_req(req), .bus_rsp(rsp), .irq(irq), .func(func), .pin_out(pin_out),
    .pin_in(pin_in), .encoder_in_a(enc[0]), .encoder_in_b(enc[1]), .encoder_index(enc[2]), .encoder_strobe(enc[3]),
    .encoder_error(enc_err), .pin_to_gpio(to_gpio), .pin_to_timer(to_timer), .pin_to_serial(to_serial),
    .encoder_filtered(filt), .timer_pin_disable_n(dis_n)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d, input logic p);
    @(posedge sys_clk);
    req <= '{wr: w, rd: !w, priv: p, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    #1 rq = rsp.rdata;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, ra[i], 32'h0, 1'b1);
      chk(rq, rv[i]);
    end
    chk(dis_n, func.gpio_a[5]);
    foreach (rows[i]) begin
      acc(1'b1, OFS_SEL2, rows[i][31:0], 1'b1);
      chk({pin_out[7], pin_out[5]}, {rows[i][32] ? func.timer[29] : func.gpio_a[7], func.gpio_a[5]});
      acc(1'b0, OFS_SEL2, 32'h0, 1'b1);
      chk(rq, rows[i][31:0]);
    end
    @(posedge sys_clk);
    pin_in <= 16'ha5c3;
    @(posedge sys_clk);
    #1 chk({to_gpio, to_timer}, {2{16'ha5c3}});
    chk(to_serial, 16'ha5c3);
    acc(1'b1, OFS_SEL2, 32'h0002_0101, 1'b0);
    chk(rsp.err, 1'h1);
    chk(irq, 1'h0);
    acc(1'b0, OFS_SEL2, 32'h0, 1'b1);
    chk(rq, RST_SEL2);
    acc(1'b1, OFS_INT_MASK, 32'h0000_0001, 1'b0);
    chk(irq, 1'h1);
    acc(1'b1, OFS_INT_STATUS, 32'h0000_0001, 1'b0);
    chk(irq, 1'h0);
    acc(1'b0, 6'h3c, 32'h0, 1'b1);
    chk(rq, 32'h0);
    acc(1'b1, OFS_TMR_DIS, 32'h0000_0002, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      enc_err <= !enc_err;
      repeat (3) @(posedge sys_clk);
      #1 chk(dis_n, !enc_err);
    end
    acc(1'b1, OFS_TMR_DIS, 32'h0, 1'b1);
    chk(dis_n, func.gpio_a[5]);
    foreach (emode[i]) begin
      acc(1'b1, OFS_ENC_FILT, emode[i], 1'b1);
      @(posedge sys_clk);
      enc <= enc + 4'h3;
      repeat (4) @(posedge sys_clk);
      #1 chk(filt, enc);
    end
    acc(1'b1, OFS_ENC_FILT, 32'h0202_0202, 1'b1);
    @(posedge sys_clk);
    // Only all zeros has stood long enough to be qualified so far
    enc <= 4'hf;
    repeat (40) @(posedge sys_clk);
    #1 chk(filt, 4'h0);
    @(posedge sys_clk);
    enc <= 4'h0;
    @(posedge sys_clk);
    enc <= 4'hf;
    repeat (40) @(posedge sys_clk);
    #1 chk(filt, 4'h0);
    repeat (40) @(posedge sys_clk);
    #1 chk(filt, 4'hf);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    acc(1'b0, OFS_ENC_FILT, 32'h0, 1'b1);
    chk(rq, RST_ENC_FILT);
    report_and_stop();
  end
endmodule
bind pfm_pin_function_mux pfm_pin_function_mux_monitor mon (
  .sys_clk, .rstn, .bus_req, .bus_rsp, .func, .pin_out, .pin_in, .pin_to_gpio, .pin_to_timer, .pin_to_serial,
  .encoder_in_a, .encoder_filtered, .timer_pin_disable_n
);
